// *** logic/cts_regs.svh ***
`ifndef CTS_REGS_SVH
`define CTS_REGS_SVH
// Register byte offsets
`define CTS_OFF_ABORT_ACK 8'h00
`define CTS_OFF_BUF_SEL 8'h04
`define CTS_OFF_ACC_CTRL 8'h08
`define CTS_OFF_TEST 8'h0c
`define CTS_OFF_IRQ_STAT 8'h10
`define CTS_OFF_IRQ_MASK 8'h14
// Acceptance control field positions
`define CTS_ACC_MODE_LSB 4
`define CTS_ACC_MODE_MSB 5
`define CTS_ACC_HIT_MSB 2
// Interrupt status bit of a new foreground message
`define CTS_IRQ_RX_BIT 3
// Reset values
`define CTS_RST_ABORT_ACK 3'h0
`define CTS_RST_BUF_SEL 3'h0
`define CTS_RST_HIT 3'h0
`define CTS_RST_TEST 8'h00
`define CTS_RST_IRQ 4'h0
`endif

// *** logic/cts_pkg.sv ***
`default_nettype none
package cts_pkg;
  typedef enum logic [1:0] {
    CTS_AM_TWO32,
    CTS_AM_FOUR16,
    CTS_AM_EIGHT8,
    CTS_AM_CLOSED
  } cts_accept_mode_t;
  typedef logic [1:0] cts_resp_t;
  localparam cts_resp_t CTS_RESP_OKAY = 2'h0;
  localparam cts_resp_t CTS_RESP_SLVERR = 2'h2;
endpackage : cts_pkg
`default_nettype wire

// *** logic/cts_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.svh"

// Contract
// - Keep one abort acknowledge bit per transmit buffer in bits 2-0.
// - Clear a buffer's abort acknowledge when its empty flag is cleared.
// - Acknowledge reads 1 if aborted, 0 if the message was sent.
// - Acknowledge register reset in init mode; software writes do nothing.
// - Only the lowest set select bit maps a buffer into the window.
// - Select register reads back only its lowest set bit.
// - Select writable only with init request and acknowledge both low; held at reset in init mode.
// - Block window access while selected buffer is scheduled (empty flag 0).
// - No buffer selected means no window access at all.
// - Mode 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - Closed filter accepts nothing; foreground buffer never reloads.
// - Acceptance control writable only in init mode; hit bits read-only.
// - Hit index is a 3-bit value in bits 2-0 naming filter 0-7.
// - Hit index follows the foreground message, updated on each shift-in.
// - Test register unavailable normally; writable in special modes.
// - Successful abort sets acknowledge and raises enabled transmit interrupt.
// - Empty flag 1 means free; 0 means message due for transmission.
module cts_ctrl (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output cts_pkg::cts_resp_t s_axi_bresp_o,
  // AXI4-Lite read
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output cts_pkg::cts_resp_t s_axi_rresp_o,
  // Mode inputs from neighbouring control logic
  input wire logic init_request_i,
  input wire logic init_acknowledge_i,
  input wire logic special_mode_i,
  // Transmit side
  input wire logic [2:0] tx_buffer_empty_flag_i,
  input wire logic [2:0] abort_done_i,
  output logic [2:0] tx_foreground_sel_o,
  output logic tx_foreground_access_ok_o,
  // Receive side
  input wire logic rx_shift_i,
  input wire logic [2:0] rx_hit_index_i,
  output cts_pkg::cts_accept_mode_t acceptance_mode_o,
  output logic filter_closed_o,
  // Test register and interrupt
  output logic [7:0] test_reg_o,
  output logic irq_o
);
  import cts_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] cts_lowest(input logic [2:0] v);
    cts_lowest = v & (~v + 3'h1);
  endfunction : cts_lowest

  function automatic logic cts_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    cts_hit = (a[7:2] == off[7:2]);
  endfunction : cts_hit

  function automatic logic cts_mapped(input logic [7:0] a);
    cts_mapped = cts_hit(a, `CTS_OFF_ABORT_ACK)
      | cts_hit(a, `CTS_OFF_BUF_SEL) | cts_hit(a, `CTS_OFF_ACC_CTRL)
      | cts_hit(a, `CTS_OFF_TEST) | cts_hit(a, `CTS_OFF_IRQ_STAT)
      | cts_hit(a, `CTS_OFF_IRQ_MASK);
  endfunction : cts_mapped

  logic init_mode;
  logic init_off;
  assign init_mode = init_request_i & init_acknowledge_i;
  assign init_off = ~init_request_i & ~init_acknowledge_i;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_full_q;
  logic aw_full_d;
  logic w_full_q;
  logic w_full_d;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic commit;
  logic wr_lane;
  logic bvalid_q;
  cts_resp_t bresp_q;
  logic awready_q;
  logic wready_q;

  assign commit = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_lane = commit & wstrb0_q;
  assign aw_full_d = (aw_full_q & ~commit)
    | (s_axi_awvalid_i & awready_q);
  assign w_full_d = (w_full_q & ~commit) | (s_axi_wvalid_i & wready_q);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      if (s_axi_awvalid_i & awready_q)
        awaddr_q <= s_axi_awaddr_i;
      if (s_axi_wvalid_i & wready_q)
      begin
        wdata_q <= s_axi_wdata_i;
        wstrb0_q <= s_axi_wstrb_i[0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= CTS_RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= cts_mapped(awaddr_q) ? CTS_RESP_OKAY : CTS_RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Abort acknowledge
  // ----------------------------------------------------------------
  logic [2:0] abort_ack_q;
  logic [2:0] empty_prev_q;
  logic [2:0] empty_clr;

  assign empty_clr = empty_prev_q & ~tx_buffer_empty_flag_i;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      abort_ack_q <= `CTS_RST_ABORT_ACK;
      empty_prev_q <= 3'h7;
    end
    else
    begin
      empty_prev_q <= tx_buffer_empty_flag_i;
      if (init_mode)
        abort_ack_q <= `CTS_RST_ABORT_ACK;
      else
        abort_ack_q <= (abort_ack_q & ~empty_clr) | abort_done_i;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer select and window
  // ----------------------------------------------------------------
  logic [2:0] sel_raw_q;
  logic [2:0] win_sel_q;
  logic win_ok_q;
  logic [2:0] sel_low;

  assign sel_low = cts_lowest(sel_raw_q);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      sel_raw_q <= `CTS_RST_BUF_SEL;
    else if (init_mode)
      sel_raw_q <= `CTS_RST_BUF_SEL;
    else if (wr_lane && init_off && cts_hit(awaddr_q, `CTS_OFF_BUF_SEL))
      sel_raw_q <= wdata_q[2:0];
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      win_sel_q <= 3'h0;
      win_ok_q <= 1'b0;
    end
    else
    begin
      win_sel_q <= sel_low;
      win_ok_q <= |(sel_low & tx_buffer_empty_flag_i);
    end
  end

  // ----------------------------------------------------------------
  // Acceptance control
  // ----------------------------------------------------------------
  cts_accept_mode_t mode_q;
  logic [2:0] hit_q;
  logic rx_take;
  logic closed_q;

  assign rx_take = rx_shift_i & (mode_q != CTS_AM_CLOSED);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      mode_q <= CTS_AM_TWO32;
    else if (wr_lane && init_mode && cts_hit(awaddr_q, `CTS_OFF_ACC_CTRL))
      mode_q <= cts_accept_mode_t'(
        wdata_q[`CTS_ACC_MODE_MSB:`CTS_ACC_MODE_LSB]);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hit_q <= `CTS_RST_HIT;
      closed_q <= 1'b0;
    end
    else
    begin
      closed_q <= (mode_q == CTS_AM_CLOSED);
      if (rx_take)
        hit_q <= rx_hit_index_i;
    end
  end

  // ----------------------------------------------------------------
  // Test register
  // ----------------------------------------------------------------
  logic [7:0] test_q;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      test_q <= `CTS_RST_TEST;
    else if (wr_lane && special_mode_i && cts_hit(awaddr_q, `CTS_OFF_TEST))
      test_q <= wdata_q[7:0];
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic irq_q;

  assign irq_set = {rx_take, abort_done_i};
  assign irq_clr = (wr_lane && cts_hit(awaddr_q, `CTS_OFF_IRQ_STAT))
    ? wdata_q[3:0] : 4'h0;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat_q <= `CTS_RST_IRQ;
      irq_mask_q <= `CTS_RST_IRQ;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr_lane && cts_hit(awaddr_q, `CTS_OFF_IRQ_MASK))
        irq_mask_q <= wdata_q[3:0];
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic arready_q;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  cts_resp_t rresp_q;
  logic [31:0] rd_mux;
  logic ar_take;

  assign ar_take = s_axi_arvalid_i & arready_q;
  assign rvalid_d = (rvalid_q & ~s_axi_rready_i) | ar_take;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (cts_hit(s_axi_araddr_i, `CTS_OFF_ABORT_ACK))
      rd_mux[2:0] = abort_ack_q;
    else if (cts_hit(s_axi_araddr_i, `CTS_OFF_BUF_SEL))
      rd_mux[2:0] = sel_low;
    else if (cts_hit(s_axi_araddr_i, `CTS_OFF_ACC_CTRL))
    begin
      rd_mux[`CTS_ACC_MODE_MSB:`CTS_ACC_MODE_LSB] = mode_q;
      rd_mux[`CTS_ACC_HIT_MSB:0] = hit_q;
    end
    else if (cts_hit(s_axi_araddr_i, `CTS_OFF_TEST))
      rd_mux[7:0] = special_mode_i ? test_q : 8'h00;
    else if (cts_hit(s_axi_araddr_i, `CTS_OFF_IRQ_STAT))
      rd_mux[3:0] = irq_stat_q;
    else if (cts_hit(s_axi_araddr_i, `CTS_OFF_IRQ_MASK))
      rd_mux[3:0] = irq_mask_q;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= CTS_RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_mux;
        rresp_q <= cts_mapped(s_axi_araddr_i) ? CTS_RESP_OKAY
                                              : CTS_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign tx_foreground_sel_o = win_sel_q;
  assign tx_foreground_access_ok_o = win_ok_q;
  assign acceptance_mode_o = mode_q;
  assign filter_closed_o = closed_q;
  assign test_reg_o = test_q;
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_abort0_unmasked;
    abort_done_i[0] && !init_mode ##1 irq_mask_q[0];
  endsequence

  a_ack_init_reset: assert property (
    init_mode |=> abort_ack_q == 3'h0)
    else $error("abort ack not reset in init mode");

  a_ack_set_abort: assert property (
    abort_done_i[1] && !init_mode |=> abort_ack_q[1])
    else $error("abort ack not set on abort");

  a_ack_clear_empty: assert property (
    $fell(tx_buffer_empty_flag_i[0]) && !abort_done_i[0] && !init_mode
    |=> !abort_ack_q[0])
    else $error("abort ack not cleared with empty flag");

  a_sel_init_hold: assert property (
    init_mode |=> sel_raw_q == 3'h0)
    else $error("select not held in init mode");

  a_sel_lowest_map: assert property (
    sel_raw_q != 3'h0 |=> $onehot(win_sel_q)
      && ((win_sel_q - 3'h1) & $past(sel_raw_q)) == 3'h0
      && (win_sel_q & $past(sel_raw_q)) != 3'h0)
    else $error("window not the lowest select bit");

  a_window_blocked: assert property (
    win_ok_q |-> (win_sel_q & $past(tx_buffer_empty_flag_i)) != 3'h0)
    else $error("window open to scheduled or no buffer");

  a_acc_locked: assert property (
    commit && !init_mode && cts_hit(awaddr_q, `CTS_OFF_ACC_CTRL)
    |=> $stable(mode_q))
    else $error("acceptance mode changed outside init");

  a_hit_update: assert property (
    rx_shift_i && mode_q != CTS_AM_CLOSED
    |=> hit_q == $past(rx_hit_index_i))
    else $error("hit index not updated on shift");

  a_closed_no_reload: assert property (
    mode_q == CTS_AM_CLOSED |=> $stable(hit_q))
    else $error("hit index moved while closed");

  a_test_locked: assert property (
    commit && !special_mode_i && cts_hit(awaddr_q, `CTS_OFF_TEST)
    |=> $stable(test_q))
    else $error("test register written in normal mode");

  a_abort_irq: assert property (
    s_abort0_unmasked |=> irq_o)
    else $error("abort did not raise interrupt");

endmodule : cts_ctrl
`default_nettype wire

// *** bench/can_tx_select_acceptance_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.svh"

module can_tx_select_acceptance_ctrl_test;
  import cts_pkg::*;

  // ---------------------------------------------
  // Signals and case table
  // ---------------------------------------------
  typedef struct packed {
    logic [31:0] wr;
    logic [2:0] empty;
    logic [31:0] rd;
    logic [2:0] sel;
    logic ok;
  } cts_row_t;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0;
  logic awready;
  logic [7:0] awaddr = 8'h00;
  logic wvalid = 1'b0;
  logic wready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic bvalid;
  logic bready = 1'b0;
  cts_resp_t bresp;
  logic arvalid = 1'b0;
  logic arready;
  logic [7:0] araddr = 8'h00;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] rdata;
  cts_resp_t rresp;
  logic init_rq = 1'b0;
  logic init_ak = 1'b0;
  logic special = 1'b0;
  logic [2:0] empty = 3'h7;
  logic [2:0] abort_done = 3'h0;
  logic [2:0] fg_sel;
  logic fg_ok;
  logic rx_shift = 1'b0;
  logic [2:0] rx_hit = 3'h0;
  cts_accept_mode_t acc_mode;
  logic closed;
  logic [7:0] test_reg;
  logic irq;
  logic [31:0] rd_data;
  cts_resp_t rd_resp;
  cts_resp_t wr_resp;
  cts_row_t rows [6];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  cts_ctrl dut (
    .mclk_i(clk), .rst_i(rst),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .init_request_i(init_rq),
    .init_acknowledge_i(init_ak), .special_mode_i(special),
    .tx_buffer_empty_flag_i(empty), .abort_done_i(abort_done),
    .tx_foreground_sel_o(fg_sel), .tx_foreground_access_ok_o(fg_ok),
    .rx_shift_i(rx_shift), .rx_hit_index_i(rx_hit),
    .acceptance_mode_o(acc_mode), .filter_closed_o(closed),
    .test_reg_o(test_reg), .irq_o(irq)
  );

  // ---------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk_val(rd_data, exp);
  endtask : rd_chk

  task automatic pulse(input logic [2:0] ab, input logic sh,
                       input logic [2:0] hit);
    @(posedge clk);
    abort_done <= ab;
    rx_shift <= sh;
    rx_hit <= hit;
    @(posedge clk);
    abort_done <= 3'h0;
    rx_shift <= 1'b0;
  endtask : pulse

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    rows[0] = '{32'h06, 3'h7, 32'h02, 3'h2, 1'b1};
    rows[1] = '{32'h03, 3'h7, 32'h01, 3'h1, 1'b1};
    rows[2] = '{32'h04, 3'h7, 32'h04, 3'h4, 1'b1};
    rows[3] = '{32'h07, 3'h7, 32'h01, 3'h1, 1'b1};
    rows[4] = '{32'h02, 3'h5, 32'h02, 3'h2, 1'b0};
    rows[5] = '{32'hf8, 3'h7, 32'h00, 3'h0, 1'b0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h0);
    rd_chk(`CTS_OFF_BUF_SEL, 32'h0);
    rd_chk(`CTS_OFF_ACC_CTRL, 32'h0);
    rd_chk(`CTS_OFF_IRQ_STAT, 32'h0);
    chk_val({31'h0, irq}, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 6; i++)
    begin
      empty <= rows[i].empty;
      axi_wr(`CTS_OFF_BUF_SEL, rows[i].wr);
      rd_chk(`CTS_OFF_BUF_SEL, rows[i].rd);
      repeat (3) @(posedge clk);
      chk_val({29'h0, fg_sel}, {29'h0, rows[i].sel});
      chk_val({31'h0, fg_ok}, {31'h0, rows[i].ok});
    end
    $display("test select_table done");
    empty <= 3'h7;
    pulse(3'h7, 1'b0, 3'h0);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h7);
    rd_chk(`CTS_OFF_IRQ_STAT, 32'h7);
    axi_wr(`CTS_OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk_val({31'h0, irq}, 32'h1);
    axi_wr(`CTS_OFF_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk);
    chk_val({31'h0, irq}, 32'h0);
    rd_chk(`CTS_OFF_IRQ_STAT, 32'h5);
    axi_wr(`CTS_OFF_ABORT_ACK, 32'h0);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h7);
    empty <= 3'h4;
    repeat (2) @(posedge clk);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h4);
    empty <= 3'h7;
    $display("test abort_ack done");
    pulse(3'h0, 1'b1, 3'h5);
    rd_chk(`CTS_OFF_ACC_CTRL, 32'h05);
    axi_wr(`CTS_OFF_ACC_CTRL, 32'h37);
    rd_chk(`CTS_OFF_ACC_CTRL, 32'h05);
    axi_wr(`CTS_OFF_BUF_SEL, 32'h04);
    init_rq <= 1'b1;
    init_ak <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h0);
    rd_chk(`CTS_OFF_BUF_SEL, 32'h0);
    axi_wr(`CTS_OFF_BUF_SEL, 32'h01);
    rd_chk(`CTS_OFF_BUF_SEL, 32'h0);
    pulse(3'h1, 1'b0, 3'h0);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      axi_wr(`CTS_OFF_ACC_CTRL, 32'h07 | (m << 4));
      rd_chk(`CTS_OFF_ACC_CTRL, 32'h05 | (m << 4));
      repeat (2) @(posedge clk);
      chk_val({30'h0, acc_mode}, m);
      chk_val({31'h0, closed}, {31'h0, m == 3});
    end
    init_rq <= 1'b0;
    init_ak <= 1'b0;
    pulse(3'h0, 1'b1, 3'h2);
    rd_chk(`CTS_OFF_ACC_CTRL, 32'h35);
    $display("test init_acceptance done");
    axi_wr(`CTS_OFF_TEST, 32'ha5);
    rd_chk(`CTS_OFF_TEST, 32'h0);
    chk_val({24'h0, test_reg}, 32'h0);
    special <= 1'b1;
    axi_wr(`CTS_OFF_TEST, 32'ha5);
    rd_chk(`CTS_OFF_TEST, 32'ha5);
    chk_val({24'h0, test_reg}, 32'ha5);
    special <= 1'b0;
    axi_wr(8'h20, 32'h1);
    chk_val({30'h0, wr_resp}, {30'h0, CTS_RESP_SLVERR});
    axi_rd(8'h20);
    chk_val({30'h0, rd_resp}, {30'h0, CTS_RESP_SLVERR});
    $display("test test_reg_unmapped done");
    axi_wr(`CTS_OFF_IRQ_STAT, 32'hf);
    axi_wr(`CTS_OFF_IRQ_MASK, 32'h1);
    chk_val({31'h0, irq}, 32'h0);
    pulse(3'h1, 1'b0, 3'h0);
    repeat (2) @(posedge clk);
    chk_val({31'h0, irq}, 32'h1);
    rd_chk(`CTS_OFF_ABORT_ACK, 32'h1);
    $display("test abort_irq done");
    axi_wr(`CTS_OFF_BUF_SEL, 32'h02);
    wstrb <= 4'h0;
    axi_wr(`CTS_OFF_BUF_SEL, 32'h01);
    rd_chk(`CTS_OFF_BUF_SEL, 32'h02);
    wstrb <= 4'hf;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`CTS_OFF_BUF_SEL, 32'h0);
    rd_chk(`CTS_OFF_ACC_CTRL, 32'h0);
    chk_val({30'h0, acc_mode}, 32'h0);
    $display("test mid_reset done");
    final_report();
  end
endmodule : can_tx_select_acceptance_ctrl_test

`default_nettype wire
